// ---- rtl/pudc_cfg.svh ----
// Constants for the presettable up/down counter
`ifndef PUDC_CFG_SVH
`define PUDC_CFG_SVH
`define PUDC_WIDTH     4
`define PUDC_BCD_MAX   4'h9
`define PUDC_BIN_MAX   4'hF
`define PUDC_MIN       4'h0
`define PUDC_CLR_VAL   4'h0
`define PUDC_PIN_IDLE  4'h3
`define PUDC_TERM_IDLE 2'h3
`endif

// ---- rtl/pudc_pkg.sv ----
// Types for the presettable up/down counter
`include "pudc_cfg.svh"
package pudc_pkg;
   typedef logic [`PUDC_WIDTH-1:0] pudc_cnt_t;
   typedef struct packed {
      logic clk_up;
      logic clk_dn;
   } pudc_clks_t;
   typedef struct packed {
      logic carry_n;
      logic borrow_n;
   } pudc_term_t;
endpackage : pudc_pkg

// ---- rtl/pudc_counter.sv ----
// Presettable four-bit up/down counter with carry and borrow
// Function
// - Four-bit counter state; BCD or binary variant chosen by parameter.
// - Clear high forces count to zero regardless of count clocks.
// - Load enable low forces count to jam inputs regardless of count clocks.
// - Rising count-up clock with count-down held high increments count.
// - Rising count-down clock with count-up held high decrements count.
// - Carry and borrow rest high during ordinary counting.
// - Carry falls low while count-up clock low at maximum count.
// - Borrow falls low while count-down clock low at minimum count.
`timescale 1ns/1ps
`default_nettype none
`include "pudc_cfg.svh"
module pudc_counter
   import pudc_pkg::*;
#(
   parameter bit BCD = 1'b1
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       clear,
   input  wire logic       load_enable_n,
   input  wire pudc_cnt_t  jam,
   input  wire pudc_clks_t cnt_clks,
   output var  pudc_cnt_t  count_r,
   output var  pudc_term_t term_r
);
   localparam pudc_cnt_t MAX_CNT = BCD ? `PUDC_BCD_MAX : `PUDC_BIN_MAX;

   // =====================================================
   // Reset release
   logic rst_s1_r;
   logic rst_n_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // =====================================================
   // Pin synchronisers
   logic [3:0] pin_s1_r;
   logic [3:0] pin_s2_r;
   pudc_cnt_t  jam_s1_r;
   pudc_cnt_t  jam_s2_r;
   // Reset state matches idle pins: clear and load off, both clocks high
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pin_s1_r <= `PUDC_PIN_IDLE;
         pin_s2_r <= `PUDC_PIN_IDLE;
         jam_s1_r <= 4'h0;
         jam_s2_r <= 4'h0;
      end else begin
         pin_s1_r <= {clear, ~load_enable_n, cnt_clks.clk_up, cnt_clks.clk_dn};
         pin_s2_r <= pin_s1_r;
         jam_s1_r <= jam;
         jam_s2_r <= jam_s1_r;
      end
   end
   logic clr_s;
   logic load_s;
   logic up_s;
   logic dn_s;
   assign clr_s  = pin_s2_r[3];
   assign load_s = pin_s2_r[2];
   assign up_s   = pin_s2_r[1];
   assign dn_s   = pin_s2_r[0];

   // =====================================================
   // Edge detection of count clocks
   logic up_d_r;
   logic dn_d_r;
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         up_d_r <= 1'b1;
         dn_d_r <= 1'b1;
      end else begin
         up_d_r <= up_s;
         dn_d_r <= dn_s;
      end
   end
   logic up_evt;
   logic dn_evt;
   assign up_evt = up_s & ~up_d_r & dn_s;
   assign dn_evt = dn_s & ~dn_d_r & up_s;

   // =====================================================
   // Count state
   function automatic logic at_max(input pudc_cnt_t c);
      at_max = (c == MAX_CNT);
   endfunction : at_max
   function automatic logic at_min(input pudc_cnt_t c);
      at_min = (c == `PUDC_MIN);
   endfunction : at_min
   // Loaded codes above the top value go to zero on the next up count
   function automatic pudc_cnt_t step_up(input pudc_cnt_t c);
      step_up = (c >= MAX_CNT) ? `PUDC_MIN : pudc_cnt_t'(c + 4'h1);
   endfunction : step_up
   function automatic pudc_cnt_t step_dn(input pudc_cnt_t c);
      step_dn = at_min(c) ? MAX_CNT : pudc_cnt_t'(c - 4'h1);
   endfunction : step_dn

   pudc_cnt_t count_nxt;
   always_comb begin
      count_nxt = count_r;
      if (clr_s) begin
         count_nxt = `PUDC_CLR_VAL;
      end else if (load_s) begin
         count_nxt = jam_s2_r;
      end else if (up_evt) begin
         count_nxt = step_up(count_r);
      end else if (dn_evt) begin
         count_nxt = step_dn(count_r);
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         count_r <= `PUDC_CLR_VAL;
      end else begin
         count_r <= count_nxt;
      end
   end

   // =====================================================
   // Carry and borrow: low while the clock is low at terminal count
   pudc_term_t term_nxt;
   always_comb begin
      term_nxt.carry_n  = ~(~up_s & at_max(count_nxt));
      term_nxt.borrow_n = ~(~dn_s & at_min(count_nxt));
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         term_r <= `PUDC_TERM_IDLE;
      end else begin
         term_r <= term_nxt;
      end
   end

   // =====================================================
   // Checks
   // Clear and load
   a_clear_wins: assert property (@(posedge clk) disable iff (!rst_n_r)
      clr_s
      |=> (count_r == `PUDC_CLR_VAL))
      else $error("count not zero after clear");
   a_clear_blocks: assert property (@(posedge clk) disable iff (!rst_n_r)
      clr_s && (up_evt || dn_evt)
      |=> (count_r == `PUDC_CLR_VAL))
      else $error("count clock acted during clear");
   a_load_jam: assert property (@(posedge clk) disable iff (!rst_n_r)
      load_s && !clr_s
      |=> (count_r == $past(jam_s2_r)))
      else $error("count not loaded from jam");
   a_load_blocks: assert property (@(posedge clk) disable iff (!rst_n_r)
      load_s && !clr_s && (up_evt || dn_evt)
      |=> (count_r == $past(jam_s2_r)))
      else $error("count clock acted during load");

   // Counting steps
   a_count_up: assert property (@(posedge clk) disable iff (!rst_n_r)
      up_evt && !clr_s && !load_s
      |=> (count_r == (($past(count_r) >= MAX_CNT) ? `PUDC_MIN : $past(count_r) + 4'h1)))
      else $error("count-up step wrong");
   a_count_down: assert property (@(posedge clk) disable iff (!rst_n_r)
      dn_evt && !up_evt && !clr_s && !load_s
      |=> (count_r == (($past(count_r) == `PUDC_MIN) ? MAX_CNT : $past(count_r) - 4'h1)))
      else $error("count-down step wrong");
   a_wrap_up: assert property (@(posedge clk) disable iff (!rst_n_r)
      up_evt && !clr_s && !load_s && at_max(count_r)
      |=> (count_r == `PUDC_MIN))
      else $error("count did not wrap to zero");
   a_wrap_down: assert property (@(posedge clk) disable iff (!rst_n_r)
      dn_evt && !up_evt && !clr_s && !load_s && at_min(count_r)
      |=> (count_r == MAX_CNT))
      else $error("count did not wrap to the top value");
   a_hold_still: assert property (@(posedge clk) disable iff (!rst_n_r)
      !clr_s && !load_s && !up_evt && !dn_evt
      |=> $stable(count_r))
      else $error("count changed without cause");
   a_up_refused: assert property (@(posedge clk) disable iff (!rst_n_r)
      up_s && !up_d_r && !dn_s && !clr_s && !load_s
      |=> $stable(count_r))
      else $error("count-up edge taken while count-down low");
   a_dn_refused: assert property (@(posedge clk) disable iff (!rst_n_r)
      dn_s && !dn_d_r && !up_s && !clr_s && !load_s
      |=> $stable(count_r))
      else $error("count-down edge taken while count-up low");
   a_range_ok: assert property (@(posedge clk) disable iff (!rst_n_r)
      !load_s && !clr_s && (count_r <= MAX_CNT)
      |=> (count_r <= MAX_CNT))
      else $error("count left its range");

   // Carry and borrow levels
   a_carry_low: assert property (@(posedge clk) disable iff (!rst_n_r)
      !up_s && at_max(count_nxt)
      |=> !term_r.carry_n)
      else $error("carry not low at maximum");
   a_borrow_low: assert property (@(posedge clk) disable iff (!rst_n_r)
      !dn_s && at_min(count_nxt)
      |=> !term_r.borrow_n)
      else $error("borrow not low at minimum");
   a_term_rest: assert property (@(posedge clk) disable iff (!rst_n_r)
      up_s && dn_s
      |=> (term_r == `PUDC_TERM_IDLE))
      else $error("carry or borrow low with both clocks high");
   a_carry_high: assert property (@(posedge clk) disable iff (!rst_n_r)
      !at_max(count_nxt)
      |=> term_r.carry_n)
      else $error("carry low away from maximum");
   a_borrow_high: assert property (@(posedge clk) disable iff (!rst_n_r)
      !at_min(count_nxt)
      |=> term_r.borrow_n)
      else $error("borrow low away from minimum");

endmodule : pudc_counter
`default_nettype wire

// ---- dv/pudc_clk_drv.sv ----
// Driving logic model for the count clock pins
`timescale 1ns/1ps
`default_nettype none
module pudc_clk_drv
   import pudc_pkg::*;
(
   input  wire logic       clk,
   output var  pudc_clks_t cnt_clks
);
   // Idle clocks rest high, like a preceding stage's carry and borrow
   initial cnt_clks = 2'h3;
   // Moves one clock line; the other keeps its level, and the task waits 4 cycles after the move
   task automatic half(input bit up, input bit lvl);
      @(posedge clk);
      #1;
      if (up) cnt_clks.clk_up = lvl;
      else cnt_clks.clk_dn = lvl;
      repeat (4) @(posedge clk);
   endtask : half
endmodule : pudc_clk_drv
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the up/down counter
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import pudc_pkg::*;
;
   typedef struct packed {logic [3:0] v; logic up; logic [3:0] e; logic [3:0] b;} pudc_row_t;
   logic       clk = 1'b0;
   logic       arst_n = 1'b0;
   logic       clear = 1'b0;
   logic       load_enable_n = 1'b1;
   pudc_cnt_t  jam = 4'h0;
   pudc_cnt_t  count_r;
   pudc_clks_t cnt_clks;
   pudc_term_t term_r;
   pudc_cnt_t  count_bin;
   pudc_term_t term_bin;
   int         n_errors = 0;
   int         total_checks = 0;
   // Loaded value, direction, decimal result, binary result
   pudc_row_t  rows [6] = '{'{4'h3, 1'h1, 4'h4, 4'h4}, '{4'h9, 1'h1, 4'h0, 4'hA},
                            '{4'h0, 1'h0, 4'h9, 4'hF}, '{4'h5, 1'h0, 4'h4, 4'h4},
                            '{4'h8, 1'h1, 4'h9, 4'h9}, '{4'hF, 1'h1, 4'h0, 4'h0}};
   always #5 clk = ~clk;
   pudc_counter i_dut (.clk(clk), .arst_n(arst_n), .clear(clear),
      .load_enable_n(load_enable_n), .jam(jam), .cnt_clks(cnt_clks),
      .count_r(count_r), .term_r(term_r));
   pudc_counter #(.BCD(1'b0)) i_dut_bin (.clk(clk), .arst_n(arst_n), .clear(clear),
      .load_enable_n(load_enable_n), .jam(jam), .cnt_clks(cnt_clks),
      .count_r(count_bin), .term_r(term_bin));
   pudc_clk_drv i_drv (.clk(clk), .cnt_clks(cnt_clks));
   // ==========================================
   // Checks and drivers
   task automatic chk_cnt(input pudc_cnt_t e, input pudc_cnt_t eb);
      #2 total_checks += 2;
      if (count_r !== e) begin
         n_errors++;
         $display("mismatch count exp %h got %h", e, count_r);
      end
      if (count_bin !== eb) begin
         n_errors++;
         $display("mismatch count_bin exp %h got %h", eb, count_bin);
      end
   endtask : chk_cnt
   task automatic chk_term(input pudc_term_t e, input pudc_term_t eb);
      #2 total_checks += 2;
      if (term_r !== e) begin
         n_errors++;
         $display("mismatch term exp %b got %b", e, term_r);
      end
      if (term_bin !== eb) begin
         n_errors++;
         $display("mismatch term_bin exp %b got %b", eb, term_bin);
      end
   endtask : chk_term
   task automatic pin(input logic c, input logic l, input pudc_cnt_t j);
      @(posedge clk);
      #1;
      clear = c;
      load_enable_n = l;
      jam = j;
      repeat (4) @(posedge clk);
   endtask : pin
   task automatic test_done;
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // ==========================================
   // Sequence
   initial begin
      repeat (2) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (3) @(posedge clk);
      chk_cnt(4'h0, 4'h0);
      chk_term(2'h3, 2'h3);
      foreach (rows[i]) begin
         pin(1'b0, 1'b0, rows[i].v);
         pin(1'b0, 1'b1, rows[i].v);
         chk_cnt(rows[i].v, rows[i].v);
         i_drv.half(rows[i].up, 1'b0);
         i_drv.half(rows[i].up, 1'b1);
         chk_cnt(rows[i].e, rows[i].b);
      end
      pin(1'b0, 1'b0, 4'h9);
      pin(1'b0, 1'b1, 4'h9);
      i_drv.half(1'b1, 1'b0);
      chk_term(2'h1, 2'h3);
      i_drv.half(1'b1, 1'b1);
      chk_term(2'h3, 2'h3);
      i_drv.half(1'b0, 1'b0);
      chk_term(2'h2, 2'h3);
      i_drv.half(1'b0, 1'b1);
      chk_cnt(4'h9, 4'h9);
      i_drv.half(1'b0, 1'b0);
      i_drv.half(1'b1, 1'b0);
      i_drv.half(1'b1, 1'b1);
      i_drv.half(1'b0, 1'b1);
      chk_cnt(4'h8, 4'h8);
      pin(1'b1, 1'b0, 4'h7);
      chk_cnt(4'h0, 4'h0);
      i_drv.half(1'b1, 1'b0);
      i_drv.half(1'b1, 1'b1);
      chk_cnt(4'h0, 4'h0);
      pin(1'b0, 1'b0, 4'h7);
      chk_cnt(4'h7, 4'h7);
      i_drv.half(1'b1, 1'b0);
      i_drv.half(1'b1, 1'b1);
      chk_cnt(4'h7, 4'h7);
      pin(1'b0, 1'b0, 4'hF);
      chk_cnt(4'hF, 4'hF);
      pin(1'b0, 1'b1, 4'hF);
      i_drv.half(1'b1, 1'b0);
      chk_term(2'h3, 2'h1);
      i_drv.half(1'b1, 1'b1);
      chk_cnt(4'h0, 4'h0);
      i_drv.half(1'b0, 1'b0);
      chk_term(2'h2, 2'h2);
      i_drv.half(1'b0, 1'b1);
      chk_cnt(4'h9, 4'hF);
      // Reset in mid-run, then one count to show the pins are taken again
      @(posedge clk);
      #1 arst_n = 1'b0;
      chk_cnt(4'h0, 4'h0);
      chk_term(2'h3, 2'h3);
      repeat (2) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (3) @(posedge clk);
      chk_cnt(4'h0, 4'h0);
      i_drv.half(1'b1, 1'b0);
      i_drv.half(1'b1, 1'b1);
      chk_cnt(4'h1, 4'h1);
      test_done();
   end
endmodule : tb_top
`default_nettype wire
